// [hdl/dsf_defs.vh]
`ifndef DSF_DEFS_VH
`define DSF_DEFS_VH
// Settle delay after the home sequence reaches cylinder zero
`define DSF_SETTLE_MS 10
`define DSF_CLK_HZ 50000000
// Cycles of settle delay at the 50 MHz drive clock
`define DSF_SETTLE_CYC ((`DSF_SETTLE_MS * `DSF_CLK_HZ) / 1000)
// Home sequence states
`define DSF_ST_IDLE 3'h0
`define DSF_ST_LOAD 3'h1
`define DSF_ST_HOME 3'h2
`define DSF_ST_SETTLE 3'h3
`define DSF_ST_READY 3'h4
`define DSF_ST_RETRACT 3'h5
// Factory unit number
`define DSF_UNIT_ZERO 3'h0
`endif

// [hdl/dsf_sync.v]
// Three-stage synchroniser; output moves once stages two and three agree
module dsf_sync (
  input wire ref_clk_i, // Drive clock
  input wire rst_n_i, // Async reset, active low
  input wire d_i, // Asynchronous input
  output reg q_o // Filtered level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // First stage feeds only the second
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q_o <= 1'b0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q_o <= s3_q;
      end
    end
  end
endmodule

// [hdl/dsf_edge.v]
// Rising-edge pulse of a synchronised level
module dsf_edge (
  input wire ref_clk_i, // Drive clock
  input wire rst_n_i, // Async reset, active low
  input wire lvl_i, // Synchronised level
  output wire rise_o // One-cycle pulse on rise
);
  reg prev_q;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= lvl_i;
    end
  end

  assign rise_o = lvl_i & ~prev_q;
endmodule

// [hdl/dsf_monitor.v]
`include "dsf_defs.vh"
module dsf_monitor #(
  parameter NHEADS = 10, // Head select lines
  parameter SETTLE_CYC = `DSF_SETTLE_CYC // Cylinder settle delay in clocks
) (
  input wire ref_clk_i, // Drive clock 50 MHz
  input wire rst_n_i, // Async reset, active low
  input wire [NHEADS-1:0] head_sel_i, // Head selects, same-clock logic
  input wire read_sel_i, // Read select
  input wire write_sel_i, // Write select
  input wire erase_sel_i, // Erase select
  input wire wdrv_a_i, // Write driver A on
  input wire wdrv_b_i, // Write driver B on
  input wire erase_drv_i, // Erase driver on
  input wire ctl_read_gate_i, // Read gate from controller
  input wire fault_sw_i, // Fault push switch, pin
  input wire start_sw_i, // Start push switch, pin
  input wire pack_present_i, // Pack installed, pin
  input wire interlocks_ok_i, // All interlocks closed, pin
  input wire heads_loaded_i, // Heads loaded sensor, pin
  input wire at_cyl_zero_i, // Carriage at cylinder zero, pin
  input wire retracted_i, // Carriage fully retracted, pin
  input wire offline_i, // Off-line switch position, pin
  input wire offline_head1_i, // Off-line head choice, pin
  input wire local_read_i, // Local read request, pin
  output reg fault_lamp_o, // Fault lamp / latch
  output reg start_lamp_o, // Start indicator lamp
  output reg spindle_on_o, // Spindle motor power
  output reg carriage_fwd_o, // Drive carriage forward to load
  output reg carriage_rev_o, // Drive carriage in reverse
  output reg on_cyl_o, // On-cylinder to controller
  output reg unit_lamp_o, // Unit-number lamp
  output reg [2:0] unit_num_o, // Reported unit number
  output reg read_gate_o, // Effective read gate
  output reg [NHEADS-1:0] read_head_o // Effective head selects for read
);
  // Settle counter width; covers the default delay with room to spare
  localparam CW = 24;
  // Terminal count, cut to the counter width on purpose
  localparam [CW-1:0] SETTLE_LAST = SETTLE_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};

  // Synchronised pin levels and switch pulses
  wire fault_sw_s; // Fault switch, synchronised
  wire start_sw_s; // Start switch, synchronised
  wire pack_s; // Pack present, synchronised
  wire ilk_s; // Interlocks closed, synchronised
  wire loaded_s; // Heads loaded, synchronised
  wire cyl0_s; // At cylinder zero, synchronised
  wire retr_s; // Carriage retracted, synchronised
  wire offl_s; // Off-line position, synchronised
  wire offh1_s; // Off-line head choice, synchronised
  wire lread_s; // Local read request, synchronised
  wire fault_press; // One-cycle fault switch press
  wire start_press; // One-cycle start switch press

  // Push switches; a press must outlast the filter to count
  dsf_sync u_s0 (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(fault_sw_i),
    .q_o(fault_sw_s)
  );
  dsf_sync u_s1 (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(start_sw_i),
    .q_o(start_sw_s)
  );

  // Pack, interlock and carriage sensors
  dsf_sync u_s2 (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(pack_present_i),
    .q_o(pack_s)
  );
  dsf_sync u_s3 (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(interlocks_ok_i),
    .q_o(ilk_s)
  );
  dsf_sync u_s4 (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(heads_loaded_i),
    .q_o(loaded_s)
  );
  dsf_sync u_s5 (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(at_cyl_zero_i),
    .q_o(cyl0_s)
  );
  dsf_sync u_s6 (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(retracted_i),
    .q_o(retr_s)
  );

  // Off-line switch and local read request
  dsf_sync u_s7 (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(offline_i),
    .q_o(offl_s)
  );
  dsf_sync u_s8 (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(offline_head1_i),
    .q_o(offh1_s)
  );
  dsf_sync u_s9 (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(local_read_i),
    .q_o(lread_s)
  );

  // Switch presses become single pulses
  dsf_edge u_e0 (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .lvl_i(fault_sw_s),
    .rise_o(fault_press)
  );
  dsf_edge u_e1 (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .lvl_i(start_sw_s),
    .rise_o(start_press)
  );

  // Detect two or more active head selects
  // Clearing the lowest set bit leaves a residue only when two or more are set
  reg [NHEADS-1:0] hs_low;
  wire multi_head;
  always @* begin
    hs_low = head_sel_i & (head_sel_i - {{(NHEADS-1){1'b0}}, 1'b1});
  end
  assign multi_head = |hs_low;

  // Illegal selection conditions, combinational from same-clock logic
  wire c_rw; // Read with write
  wire c_re; // Read with erase
  wire c_e_nowr; // Erase without a write driver
  wire c_e_both; // Erase with both write drivers
  wire c_wr_noe; // Write driver without erase driver
  wire c_nocyl; // Select while not on cylinder
  wire fault_cond; // Any illegal selection
  assign c_rw = read_sel_i & write_sel_i;
  assign c_re = read_sel_i & erase_sel_i;
  assign c_e_nowr = erase_sel_i & ~wdrv_a_i & ~wdrv_b_i;
  assign c_e_both = erase_sel_i & wdrv_a_i & wdrv_b_i;
  assign c_wr_noe = (wdrv_a_i | wdrv_b_i) & ~erase_drv_i;
  assign c_nocyl = (read_sel_i | write_sel_i | erase_sel_i) & ~on_cyl_o;
  // One condition alone is enough to set the latch
  assign fault_cond = multi_head | c_rw | c_re | c_e_nowr | c_e_both | c_wr_noe | c_nocyl;

  // Fault latch; a present condition wins over the clear so nothing is lost
  // A condition shorter than one clock is not seen; the select lines are clocked
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_lamp_o <= 1'b0;
    end else if (fault_cond) begin
      fault_lamp_o <= 1'b1;
    end else if (fault_press) begin
      fault_lamp_o <= 1'b0;
    end
  end

  // Home sequence
  reg [2:0] st_q; // Sequence state
  reg [2:0] st_d;
  reg [CW-1:0] cnt_q; // Settle delay count
  reg [CW-1:0] cnt_d;
  reg run_q; // Spindle run request
  reg run_d;

  always @* begin
    st_d = st_q;
    cnt_d = cnt_q;
    run_d = run_q;
    // Start press toggles run; refused without pack and interlocks
    if (start_press) begin
      if (run_q) begin
        run_d = 1'b0;
      end else if (pack_s & ilk_s) begin
        run_d = 1'b1;
      end
    end
    // Losing pack or interlocks behaves like a stop
    if (~pack_s | ~ilk_s) begin
      run_d = 1'b0;
    end
    // Load forward, home in reverse, settle, then report on cylinder
    case (st_q)
      `DSF_ST_IDLE: begin
        if (run_d) begin
          st_d = `DSF_ST_LOAD;
        end
      end
      `DSF_ST_LOAD: begin
        if (!run_d) begin
          st_d = `DSF_ST_RETRACT;
        end else if (loaded_s) begin
          st_d = `DSF_ST_HOME;
        end
      end
      `DSF_ST_HOME: begin
        cnt_d = {CW{1'b0}};
        if (!run_d) begin
          st_d = `DSF_ST_RETRACT;
        end else if (cyl0_s) begin
          st_d = `DSF_ST_SETTLE;
        end
      end
      `DSF_ST_SETTLE: begin
        // Count starts at zero, so the last value is one below the delay
        cnt_d = cnt_q + {{(CW-1){1'b0}}, 1'b1};
        if (!run_d) begin
          st_d = `DSF_ST_RETRACT;
        end else if (cnt_q == SETTLE_LAST) begin
          st_d = `DSF_ST_READY;
        end
      end
      `DSF_ST_READY: begin
        if (!run_d) begin
          st_d = `DSF_ST_RETRACT;
        end
      end
      `DSF_ST_RETRACT: begin
        if (run_d) begin
          st_d = `DSF_ST_LOAD;
        end else if (retr_s) begin
          st_d = `DSF_ST_IDLE;
        end
      end
      default: begin
        st_d = `DSF_ST_IDLE;
      end
    endcase
  end

  // State and registered outputs
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // Motors off and lamps dark while reset is held
      st_q <= `DSF_ST_IDLE;
      cnt_q <= {CW{1'b0}};
      run_q <= 1'b0;
      start_lamp_o <= 1'b0;
      spindle_on_o <= 1'b0;
      carriage_fwd_o <= 1'b0;
      carriage_rev_o <= 1'b0;
      on_cyl_o <= 1'b0;
      unit_lamp_o <= 1'b0;
      unit_num_o <= `DSF_UNIT_ZERO;
      read_gate_o <= 1'b0;
      read_head_o <= {NHEADS{1'b0}};
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      run_q <= run_d;
      // Start lamp, motors and on-cylinder follow the next state; the unit lamp follows the loaded sensor
      start_lamp_o <= run_d;
      spindle_on_o <= run_d;
      carriage_fwd_o <= (st_d == `DSF_ST_LOAD);
      carriage_rev_o <= (st_d == `DSF_ST_HOME) | (st_d == `DSF_ST_RETRACT);
      on_cyl_o <= (st_d == `DSF_ST_READY);
      unit_lamp_o <= loaded_s;
      unit_num_o <= `DSF_UNIT_ZERO;
      // Read control goes to the drive when off-line
      // On-line the controller's gate and heads pass through one register
      if (offl_s) begin
        read_gate_o <= lread_s;
        read_head_o <= {{(NHEADS-2){1'b0}}, offh1_s, ~offh1_s};
      end else begin
        read_gate_o <= ctl_read_gate_i;
        read_head_o <= head_sel_i;
      end
    end
  end
endmodule

// [bench/dsf_ctl_model.sv]
// Controller side: launches head and select lines on the drive clock
module dsf_ctl_model #(parameter NHEADS = 10) (
  input logic ref_clk_i, // Drive clock
  input logic [NHEADS-1:0] hd_i, // Wanted heads
  input logic [6:0] cmd_i, // {rd,wr,er,wa,wb,ed,gate}
  output logic [NHEADS-1:0] head_sel_o, // Head selects
  output logic [6:0] sel_o // Select and driver lines
);
  // Lines are unknown only before the first edge, while reset holds the drive
  always @(posedge ref_clk_i) begin
    head_sel_o <= hd_i;
    sel_o <= cmd_i;
  end
endmodule

// [bench/dsf_chk_checker.sv]
module dsf_chk #(parameter NHEADS = 10) (
  input logic ref_clk_i, // Drive clock
  input logic rst_n_i, // Reset, active low
  input logic [NHEADS-1:0] head_sel_i, // Head selects
  input logic read_sel_i, // Read select
  input logic write_sel_i, // Write select
  input logic erase_sel_i, // Erase select
  input logic wdrv_a_i, // Write driver A
  input logic wdrv_b_i, // Write driver B
  input logic erase_drv_i, // Erase driver
  input logic fault_lamp_o, // Fault latch
  input logic on_cyl_o, // On cylinder
  input logic [2:0] unit_num_o // Unit number
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Any illegal selection; a clean latch must stay clean without one
  logic wd, cond;
  assign wd = wdrv_a_i | wdrv_b_i;
  assign cond = ($countones(head_sel_i) > 1) | (read_sel_i & (write_sel_i | erase_sel_i))
    | (erase_sel_i & (!wd | (wdrv_a_i & wdrv_b_i))) | (wd & !erase_drv_i)
    | ((read_sel_i | write_sel_i | erase_sel_i) & !on_cyl_o);
  sequence s_off_cyl;
    (read_sel_i | write_sel_i | erase_sel_i) && !on_cyl_o;
  endsequence
  a_multi_head: assert property ($countones(head_sel_i) > 1 |=> fault_lamp_o) else $error("multi head");
  a_read_write: assert property (read_sel_i && write_sel_i |=> fault_lamp_o) else $error("read write");
  a_read_erase: assert property (read_sel_i && erase_sel_i |=> fault_lamp_o) else $error("read erase");
  a_erase_no_wdrv: assert property (erase_sel_i && !wd |=> fault_lamp_o) else $error("erase alone");
  a_erase_both_wdrv: assert property (erase_sel_i && wdrv_a_i && wdrv_b_i |=> fault_lamp_o)
    else $error("erase both");
  a_wdrv_no_erase: assert property (wd && !erase_drv_i |=> fault_lamp_o) else $error("no erase drv");
  a_sel_off_cyl: assert property (s_off_cyl |=> fault_lamp_o) else $error("off cylinder");
  a_clear_stays: assert property (!fault_lamp_o && !cond |=> !fault_lamp_o) else $error("false set");
  a_set_wins: assert property (fault_lamp_o && cond |=> fault_lamp_o) else $error("cleared under fault");
  a_unit_zero: assert property (unit_num_o == 3'h0) else $error("unit not zero");
endmodule
bind dsf_monitor dsf_chk #(.NHEADS(NHEADS)) u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .head_sel_i(head_sel_i), .read_sel_i(read_sel_i), .write_sel_i(write_sel_i), .erase_sel_i(erase_sel_i),
  .wdrv_a_i(wdrv_a_i), .wdrv_b_i(wdrv_b_i), .erase_drv_i(erase_drv_i), .fault_lamp_o(fault_lamp_o),
  .on_cyl_o(on_cyl_o), .unit_num_o(unit_num_o));

// [bench/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam NH = 10;
  localparam SC = 20;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, fsw = 1'b0, ssw = 1'b0, pack = 1'b0, ilk = 1'b0;
  logic ld = 1'b0, cyl0 = 1'b0, retr = 1'b0, offl = 1'b0, offh1 = 1'b0, lrd = 1'b0;
  logic [NH-1:0] hd = '0;
  logic [6:0] cmd = '0;
  wire [NH-1:0] hsel, rhead;
  wire [6:0] s;
  wire flt, slamp, spin, fwd, rev, oncyl, ulamp, rgate;
  wire [2:0] unum;
  int failures = 0, num_checks = 0, cyc = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  dsf_ctl_model #(.NHEADS(NH)) u_ctl (.ref_clk_i(ref_clk_i), .hd_i(hd), .cmd_i(cmd), .head_sel_o(hsel), .sel_o(s));
  dsf_monitor #(.NHEADS(NH), .SETTLE_CYC(SC)) u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .head_sel_i(hsel), .read_sel_i(s[6]), .write_sel_i(s[5]), .erase_sel_i(s[4]), .wdrv_a_i(s[3]),
    .wdrv_b_i(s[2]), .erase_drv_i(s[1]), .ctl_read_gate_i(s[0]), .fault_sw_i(fsw), .start_sw_i(ssw),
    .pack_present_i(pack), .interlocks_ok_i(ilk), .heads_loaded_i(ld), .at_cyl_zero_i(cyl0),
    .retracted_i(retr), .offline_i(offl), .offline_head1_i(offh1), .local_read_i(lrd),
    .fault_lamp_o(flt), .start_lamp_o(slamp), .spindle_on_o(spin), .carriage_fwd_o(fwd), .carriage_rev_o(rev),
    .on_cyl_o(oncyl), .unit_lamp_o(ulamp), .unit_num_o(unum), .read_gate_o(rgate), .read_head_o(rhead));
  task summarize();
    if (failures == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      summarize();
    end
  end
  task tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #2;
  endtask
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Switches pass a synchroniser, so hold them well past its depth
  task press(input bit f);
    if (f) fsw = 1'b1;
    else ssw = 1'b1;
    tick(8);
    fsw = 1'b0;
    ssw = 1'b0;
    tick(8);
  endtask
  task fcase(input logic [NH-1:0] h, input logic [6:0] c);
    hd = h;
    cmd = c;
    tick(3);
    chk("fault set", 16'h1, flt);
    hd = '0;
    cmd = '0;
    tick(3);
    chk("fault held", 16'h1, flt);
    press(1'b1);
    chk("fault cleared", 16'h0, flt);
    tick(6);
    chk("fault stays clear", 16'h0, flt);
  endtask
  initial begin
    tick(6);
    rst_n_i = 1'b1;
    tick(8);
    chk("unit number", 16'h0, unum);
    fcase('0, 7'h40);
    press(1'b0);
    chk("start refused", 16'h0, spin);
    chk("start lamp dark", 16'h0, slamp);
    pack = 1'b1;
    ilk = 1'b1;
    tick(8);
    press(1'b0);
    chk("spindle on", 16'h1, spin);
    chk("start lamp lit", 16'h1, slamp);
    chk("carriage load", 16'h1, fwd);
    ld = 1'b1;
    tick(8);
    chk("unit lamp on", 16'h1, ulamp);
    chk("carriage home", 16'h1, rev);
    cyl0 = 1'b1;
    tick(8);
    chk("settling", 16'h0, oncyl);
    tick(SC);
    chk("on cylinder", 16'h1, oncyl);
    // Legal read and legal write must leave the latch alone
    cmd = 7'h40;
    tick(3);
    chk("legal read", 16'h0, flt);
    cmd = 7'h3A;
    tick(3);
    chk("legal write", 16'h0, flt);
    cmd = '0;
    tick(3);
    fcase(10'h003, 7'h00);
    fcase('0, 7'h60);
    fcase('0, 7'h5A);
    fcase('0, 7'h10);
    fcase('0, 7'h1E);
    fcase('0, 7'h08);
    // A press while the condition stands must not clear the latch
    cmd = 7'h08;
    press(1'b1);
    chk("clear refused", 16'h1, flt);
    cmd = '0;
    tick(3);
    press(1'b1);
    chk("clear after", 16'h0, flt);
    offl = 1'b1;
    offh1 = 1'b1;
    lrd = 1'b1;
    tick(8);
    chk("local gate", 16'h1, rgate);
    chk("local head1", 16'h2, rhead);
    offh1 = 1'b0;
    tick(8);
    chk("local head0", 16'h1, rhead);
    offl = 1'b0;
    lrd = 1'b0;
    hd = 10'h004;
    cmd = 7'h01;
    tick(8);
    chk("ctl gate", 16'h1, rgate);
    chk("ctl head", 16'h4, rhead);
    hd = '0;
    cmd = '0;
    press(1'b0);
    chk("spindle off", 16'h0, spin);
    chk("start lamp off", 16'h0, slamp);
    chk("carriage retract", 16'h1, rev);
    retr = 1'b1;
    ld = 1'b0;
    cyl0 = 1'b0;
    tick(8);
    chk("retract done", 16'h0, rev);
    chk("unit lamp off", 16'h0, ulamp);
    summarize();
  end
endmodule
